// ### hw/nts_pkg.sv
// Constants and types for the streaming store path.
// Assumes a 16-byte store chunk and a 64-byte cache line.
//
// Notes on behaviour
// - Streaming store to uncacheable or write-protect region goes out as ordered uncached store.
// - Streaming store to write-combining region simply uses write-combining handling.
// - Streaming store hitting a cached cacheable line keeps cache and memory consistent.
// - First-level hit merges the store bytes into the cached line in place.
// - Second-level hit flushes that line plus the store data to memory.
// - Cacheable-region miss is weakly ordered and write-combined.
// - Miss never allocates a cache line; successive stores may be combined.
// - Fence pushes all buffered combining data out before completing.
// - In-place update of a cached line is not pushed out by a later fence.
// - Reads from write-combining regions never fill the caches.
// - Bus memory type of a combined line is that of its first store.
// - Packed single streaming store writes a whole 16-byte unit.
// - Packed single streaming store faults when address is not 16-byte aligned.
// - Masked stores write a byte only when its mask byte top bit is set.
// - Masked stores take their address from the destination index register.
// - Streaming stores outside uncacheable and write-protect regions are weakly ordered; none allocate cache lines.
// - Writes to the same line merge; last value per byte wins.
// - Fence makes earlier stores visible before any later store.
package nts_pkg;
	localparam int CHUNK_W = 128;
	localparam int CHUNK_BYTES = 16;
	localparam int LINE_BYTES = 64;
	localparam int LINE_CHUNKS = 4;
	localparam int CHUNK_IDX_W = 2;
	localparam int CHUNK_OFF_W = 4;
	localparam int LINE_OFF_W = 6;
	localparam int HALF_BYTES = 8;
	localparam logic [CHUNK_IDX_W-1:0] LAST_CHUNK = 2'h3;
	localparam logic [CHUNK_BYTES-1:0] BE_FULL = 16'hffff;
	localparam logic [CHUNK_BYTES-1:0] BE_LOW_HALF = 16'h00ff;
	localparam logic [CHUNK_BYTES-1:0] BE_HIGH_HALF = 16'hff00;
	localparam logic [CHUNK_OFF_W-1:0] ALIGN_ZERO = 4'h0;

	typedef enum logic [2:0] {
		uncacheable_type,
		write_combining_type,
		write_through_type,
		write_protect_type,
		write_back_type
	} mem_type_e;

	typedef enum logic [2:0] {
		plain_store,
		stream_store_packed_single,
		stream_store_quad,
		stream_store_double_quad,
		masked_stream_store_quad,
		masked_stream_store_wide
	} st_kind_e;
endpackage : nts_pkg

// ### hw/wc_mem_if.sv
// Carrier between the store path and its combining line memory.
// Assumes a single clock shared by both ends.
`timescale 1ns/10ps
interface wc_mem_if #(parameter int WIDTH = 128, parameter int IDX_W = 2);
	logic wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [WIDTH/8-1:0] wr_be;
	logic [WIDTH-1:0] wr_data;
	logic rd_en;
	logic [IDX_W-1:0] rd_idx;
	logic [WIDTH-1:0] rd_data;
	modport owner(output wr_en, wr_idx, wr_be, wr_data, rd_en, rd_idx, input rd_data);
	modport mem(input wr_en, wr_idx, wr_be, wr_data, rd_en, rd_idx, output rd_data);
endinterface : wc_mem_if

// ### hw/wc_line_mem.sv
// Byte-writable chunk memory holding one combining line.
// Assumes reads are one cycle; read data hold until the next read.
`timescale 1ns/10ps
module wc_line_mem #(
	parameter int WIDTH = 128,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Memory port
	wc_mem_if.mem m
);
	for (genvar b = 0; b < WIDTH / 8; b++) begin : g_lane
		logic [7:0] lane_q [DEPTH];
		logic [7:0] rd_q;
		// Per-byte write keeps the last value of each byte
		always_ff @(posedge i_clk) begin
			if (m.wr_en && m.wr_be[b]) begin
				lane_q[m.wr_idx] <= m.wr_data[b*8 +: 8];
			end
		end
		always_ff @(posedge i_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				rd_q <= 8'h00;
			end else if (m.rd_en) begin
				rd_q <= lane_q[m.rd_idx];
			end
		end
		assign m.rd_data[b*8 +: 8] = rd_q;
	end
endmodule : wc_line_mem

// ### hw/nontemporal_store_path.sv
// Streaming store path: picks uncached, combining, in-place or flush handling.
// Assumes the lookup result arrives with the request; the bus may stall by holding off ready.
`timescale 1ns/10ps
module nontemporal_store_path #(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Store request
	input wire logic i_st_valid,
	output logic o_st_ready,
	input wire nts_pkg::st_kind_e i_st_kind,
	input wire logic i_st_nt,
	input wire nts_pkg::mem_type_e i_st_type,
	input wire logic [ADDR_W-1:0] i_st_addr,
	input wire logic [ADDR_W-1:0] i_dest_index,
	input wire logic [nts_pkg::CHUNK_W-1:0] i_st_data,
	input wire logic [nts_pkg::CHUNK_W-1:0] i_st_mask,
	// Cache lookup result
	input wire logic i_lk_l1_hit,
	input wire logic i_lk_l2_hit,
	// Store fence
	input wire logic i_fence,
	output logic o_fence_ready,
	output logic o_fence_done,
	// First-level in-place merge
	output logic o_l1_wr_valid,
	output logic [ADDR_W-1:0] o_l1_wr_addr,
	output logic [nts_pkg::CHUNK_W-1:0] o_l1_wr_data,
	output logic [nts_pkg::CHUNK_BYTES-1:0] o_l1_wr_be,
	// Second-level flush with data
	output logic o_l2_flush_valid,
	output logic [ADDR_W-1:0] o_l2_flush_addr,
	output logic [nts_pkg::CHUNK_W-1:0] o_l2_flush_data,
	output logic [nts_pkg::CHUNK_BYTES-1:0] o_l2_flush_be,
	// System bus write
	output logic o_bus_valid,
	input wire logic i_bus_ready,
	output logic [ADDR_W-1:0] o_bus_addr,
	output logic [nts_pkg::CHUNK_W-1:0] o_bus_data,
	output logic [nts_pkg::CHUNK_BYTES-1:0] o_bus_be,
	output nts_pkg::mem_type_e o_bus_type,
	output logic o_bus_ordered,
	// Alignment fault
	output logic o_gp_fault,
	output logic [ADDR_W-1:0] o_gp_fault_addr,
	// Read fill permission and status
	input wire nts_pkg::mem_type_e i_rd_type,
	output logic o_rd_fill_ok,
	output logic o_wc_busy
);
	typedef enum {st_idle, st_uncached, st_drain_rd, st_drain_wr} state_e;
	typedef enum {pth_fault, pth_uncached, pth_wc, pth_l1, pth_l2} path_e;

	state_e state_q;
	path_e path;
	logic [ADDR_W-1:0] eff_addr, uc_addr_q;
	logic [nts_pkg::CHUNK_BYTES-1:0] mask_msb, st_be, chunk_be, bus_be_q, uc_be_q;
	logic [nts_pkg::CHUNK_W-1:0] st_lane, uc_data_q;
	logic [nts_pkg::CHUNK_IDX_W-1:0] chunk_idx, drain_idx_q;
	logic [nts_pkg::LINE_BYTES-1:0] placed, wc_be_q;
	logic masked_op, misaligned, cacheable, need_drain, st_take, fence_take;
	logic last_chunk, drain_done, wc_valid_q, fence_pend_q, fence_done_q;
	logic [ADDR_W-1:nts_pkg::LINE_OFF_W] wc_line_q;
	nts_pkg::mem_type_e wc_type_q, uc_type_q;

	wc_mem_if #(.WIDTH(nts_pkg::CHUNK_W), .IDX_W(nts_pkg::CHUNK_IDX_W)) mif();

	wc_line_mem #(.WIDTH(nts_pkg::CHUNK_W), .DEPTH(nts_pkg::LINE_CHUNKS)) u_mem (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.m(mif.mem)
	);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// Mask byte top bits select the bytes to write
	for (genvar i = 0; i < nts_pkg::CHUNK_BYTES; i++) begin : g_mask
		assign mask_msb[i] = i_st_mask[i*8 + 7];
	end

	// Request decode
	always_comb begin
		masked_op = (i_st_kind == nts_pkg::masked_stream_store_quad) ||
			(i_st_kind == nts_pkg::masked_stream_store_wide);
		eff_addr = masked_op ? i_dest_index : i_st_addr;
		chunk_idx = eff_addr[nts_pkg::LINE_OFF_W-1:nts_pkg::CHUNK_OFF_W];
		st_lane = i_st_data;
		case (i_st_kind)
			nts_pkg::stream_store_quad: begin
				st_be = eff_addr[3] ? nts_pkg::BE_HIGH_HALF : nts_pkg::BE_LOW_HALF;
				st_lane = {2{i_st_data[63:0]}};
			end
			nts_pkg::masked_stream_store_quad: begin
				st_be = eff_addr[3] ? {mask_msb[7:0], 8'h00} : {8'h00, mask_msb[7:0]};
				st_lane = {2{i_st_data[63:0]}};
			end
			nts_pkg::masked_stream_store_wide: begin
				st_be = mask_msb;
			end
			default: begin
				st_be = nts_pkg::BE_FULL;
			end
		endcase
		misaligned = (i_st_kind == nts_pkg::stream_store_packed_single) &&
			(eff_addr[nts_pkg::CHUNK_OFF_W-1:0] != nts_pkg::ALIGN_ZERO);
		placed = {48'h0000_0000_0000, st_be} << {chunk_idx, 4'h0};
		cacheable = (i_st_type == nts_pkg::write_back_type) ||
			(i_st_type == nts_pkg::write_through_type);
		// Alignment fault first, then memory type, then lookup result
		if (misaligned) begin
			path = pth_fault;
		end else if (i_st_type == nts_pkg::uncacheable_type ||
			i_st_type == nts_pkg::write_protect_type) begin
			path = pth_uncached;
		end else if (!cacheable) begin
			path = pth_wc;
		end else if (!i_st_nt || i_lk_l1_hit) begin
			path = pth_l1;
		end else if (i_lk_l2_hit) begin
			path = pth_l2;
		end else begin
			path = pth_wc;
		end
		need_drain = wc_valid_q && ((path == pth_uncached) || ((path == pth_wc) &&
			(eff_addr[ADDR_W-1:nts_pkg::LINE_OFF_W] != wc_line_q)));
	end

	assign o_fence_ready = (state_q == st_idle);
	assign fence_take = i_fence && (state_q == st_idle);
	assign o_st_ready = (state_q == st_idle) && !i_fence && !need_drain;
	assign st_take = i_st_valid && o_st_ready;
	assign chunk_be = wc_be_q[drain_idx_q*nts_pkg::CHUNK_BYTES +: nts_pkg::CHUNK_BYTES];
	assign last_chunk = (drain_idx_q == nts_pkg::LAST_CHUNK);
	assign drain_done = ((state_q == st_drain_rd) && (chunk_be == 16'h0000) && last_chunk) ||
		((state_q == st_drain_wr) && i_bus_ready && last_chunk);

	// Control sequence
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= st_idle;
		end else begin
			case (state_q)
				st_idle: begin
					if (fence_take && wc_valid_q) begin
						state_q <= st_drain_rd;
					end else if (i_st_valid && !i_fence && need_drain) begin
						state_q <= st_drain_rd;
					end else if (st_take && path == pth_uncached) begin
						state_q <= st_uncached;
					end
				end
				st_uncached: begin
					if (i_bus_ready) begin
						state_q <= st_idle;
					end
				end
				st_drain_rd: begin
					if (chunk_be != 16'h0000) begin
						state_q <= st_drain_wr;
					end else if (last_chunk) begin
						state_q <= st_idle;
					end
				end
				st_drain_wr: begin
					if (i_bus_ready) begin
						state_q <= last_chunk ? st_idle : st_drain_rd;
					end
				end
				default: begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	// Drain chunk index and beat byte enables
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			drain_idx_q <= 2'h0;
			bus_be_q <= 16'h0000;
		end else if (state_q == st_idle) begin
			drain_idx_q <= 2'h0;
		end else if (state_q == st_drain_rd) begin
			bus_be_q <= chunk_be;
			if (chunk_be == 16'h0000 && !last_chunk) begin
				drain_idx_q <= drain_idx_q + 2'h1;
			end
		end else if (state_q == st_drain_wr && i_bus_ready && !last_chunk) begin
			drain_idx_q <= drain_idx_q + 2'h1;
		end
	end

	// Combining line state, no cache allocation
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wc_valid_q <= 1'b0;
			wc_line_q <= '0;
			wc_type_q <= nts_pkg::uncacheable_type;
			wc_be_q <= 64'h0000_0000_0000_0000;
		end else if (drain_done) begin
			wc_valid_q <= 1'b0;
			wc_be_q <= 64'h0000_0000_0000_0000;
		end else if (st_take && path == pth_wc) begin
			if (!wc_valid_q) begin
				wc_valid_q <= 1'b1;
				wc_line_q <= eff_addr[ADDR_W-1:nts_pkg::LINE_OFF_W];
				wc_type_q <= i_st_type;
				wc_be_q <= placed;
			end else begin
				wc_be_q <= wc_be_q | placed;
			end
		end
	end

	// Fence tracking
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fence_pend_q <= 1'b0;
			fence_done_q <= 1'b0;
		end else begin
			fence_done_q <= (fence_take && !wc_valid_q) || (drain_done && fence_pend_q);
			if (fence_take && wc_valid_q) begin
				fence_pend_q <= 1'b1;
			end else if (drain_done) begin
				fence_pend_q <= 1'b0;
			end
		end
	end

	// Uncached store capture
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			uc_addr_q <= '0;
			uc_data_q <= '0;
			uc_be_q <= 16'h0000;
			uc_type_q <= nts_pkg::uncacheable_type;
		end else if (st_take && path == pth_uncached) begin
			uc_addr_q <= {eff_addr[ADDR_W-1:nts_pkg::CHUNK_OFF_W], nts_pkg::ALIGN_ZERO};
			uc_data_q <= st_lane;
			uc_be_q <= st_be;
			uc_type_q <= i_st_type;
		end
	end

	// In-place merge, second-level flush and fault outputs
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_l1_wr_valid <= 1'b0;
			o_l2_flush_valid <= 1'b0;
			o_gp_fault <= 1'b0;
			o_l1_wr_addr <= '0;
			o_l1_wr_data <= '0;
			o_l1_wr_be <= 16'h0000;
			o_l2_flush_addr <= '0;
			o_l2_flush_data <= '0;
			o_l2_flush_be <= 16'h0000;
			o_gp_fault_addr <= '0;
		end else begin
			o_l1_wr_valid <= st_take && (path == pth_l1);
			o_l2_flush_valid <= st_take && (path == pth_l2);
			o_gp_fault <= st_take && (path == pth_fault);
			if (st_take) begin
				o_l1_wr_addr <= {eff_addr[ADDR_W-1:nts_pkg::CHUNK_OFF_W], nts_pkg::ALIGN_ZERO};
				o_l1_wr_data <= st_lane;
				o_l1_wr_be <= st_be;
				o_l2_flush_addr <= {eff_addr[ADDR_W-1:nts_pkg::CHUNK_OFF_W], nts_pkg::ALIGN_ZERO};
				o_l2_flush_data <= st_lane;
				o_l2_flush_be <= st_be;
				o_gp_fault_addr <= eff_addr;
			end
		end
	end

	// Line memory access
	assign mif.wr_en = st_take && (path == pth_wc);
	assign mif.wr_idx = chunk_idx;
	assign mif.wr_be = st_be;
	assign mif.wr_data = st_lane;
	assign mif.rd_en = (state_q == st_drain_rd) && (chunk_be != 16'h0000);
	assign mif.rd_idx = drain_idx_q;

	// Bus beat
	assign o_bus_valid = (state_q == st_uncached) || (state_q == st_drain_wr);
	assign o_bus_ordered = (state_q == st_uncached);
	assign o_bus_addr = (state_q == st_uncached) ? uc_addr_q :
		{wc_line_q, drain_idx_q, nts_pkg::ALIGN_ZERO};
	assign o_bus_data = (state_q == st_uncached) ? uc_data_q : mif.rd_data;
	assign o_bus_be = (state_q == st_uncached) ? uc_be_q : bus_be_q;
	assign o_bus_type = (state_q == st_uncached) ? uc_type_q : wc_type_q;
	assign o_fence_done = fence_done_q;
	assign o_wc_busy = wc_valid_q;
	assign o_rd_fill_ok = (i_rd_type == nts_pkg::write_back_type) ||
		(i_rd_type == nts_pkg::write_through_type);

	a_uc_kept_type: assert property (st_take && path == pth_uncached |=>
		o_bus_valid && o_bus_ordered && o_bus_type == $past(i_st_type))
		else $error("uncached store lost its ordering or type");
	a_wc_region_combine: assert property (st_take && i_st_type == nts_pkg::write_combining_type
		&& !misaligned |-> mif.wr_en ##1 wc_valid_q)
		else $error("write-combining store not buffered");
	a_l1_merge_bytes: assert property (st_take && path == pth_l1 |=>
		o_l1_wr_valid && o_l1_wr_be == $past(st_be) && !o_bus_valid)
		else $error("first-level merge wrong");
	a_l2_flush_data: assert property (st_take && path == pth_l2 |=>
		o_l2_flush_valid && o_l2_flush_data == $past(st_lane))
		else $error("second-level flush wrong");
	a_miss_no_alloc: assert property (st_take && path == pth_wc |=>
		!o_l1_wr_valid && !o_l2_flush_valid)
		else $error("miss touched the caches");
	a_fence_empty_done: assert property (fence_take && !wc_valid_q |=> o_fence_done)
		else $error("fence on empty buffer not done");
	a_fence_done_drained: assert property (o_fence_done |-> !wc_valid_q)
		else $error("fence done with data still buffered");
	a_first_type_kept: assert property (st_take && path == pth_wc && wc_valid_q |=>
		wc_type_q == $past(wc_type_q))
		else $error("line type changed after first store");
	a_align_fault: assert property (st_take && misaligned |-> !mif.wr_en ##1
		o_gp_fault && !o_l1_wr_valid && !o_bus_valid)
		else $error("misaligned store not faulted");
	a_mask_bytes: assert property (st_take && path == pth_l1 &&
		i_st_kind == nts_pkg::masked_stream_store_wide |=> o_l1_wr_be == $past(mask_msb))
		else $error("mask bytes wrong");
	a_bytes_collapse: assert property (st_take && path == pth_wc && wc_valid_q |=>
		wc_be_q == ($past(wc_be_q) | $past(placed)))
		else $error("byte valid merge wrong");
	a_fence_blocks: assert property (fence_pend_q |-> !o_st_ready)
		else $error("store taken past a pending fence");

	c_l1_path: cover property (st_take && path == pth_l1);
	c_l2_path: cover property (st_take && path == pth_l2);
	c_drain_beat: cover property (state_q == st_drain_wr && i_bus_ready);
	c_fence_drain: cover property (fence_pend_q ##1 o_fence_done);
endmodule : nontemporal_store_path

// ### testbench/bus_agent.sv
// System bus agent facing the store path's write port.
// Assumes one clock; ready is random with at most four stalls in a row.
`timescale 1ns/10ps
module bus_agent (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Write port
	input wire logic i_valid,
	output logic o_ready
);
	integer seed;
	logic [1:0] stall_q;
	initial seed = 32'h082c;
	// Random ready, forced high after four stalls
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ready <= 1'b0;
			stall_q <= 2'h0;
		end else begin
			o_ready <= (stall_q == 2'h3) || ($random(seed) % 2 != 0);
			stall_q <= (o_ready || !i_valid) ? 2'h0 : stall_q + 2'h1;
		end
	end
endmodule : bus_agent

// ### testbench/test_nontemporal_store_path.sv
// Self-checking bench for the streaming store path: stores and fences are
// driven, expected results queued and every output pulse checked in order.
// Assumes bus_agent answers the bus write port.
`timescale 1ns/10ps
module test_nontemporal_store_path;
	typedef struct {
		logic [2:0] k;
		logic [31:0] a;
		logic [127:0] d;
		logic [15:0] be;
		logic [2:0] ty;
		logic ord;
	} exp_s;
	logic i_clk, i_rstn, i_st_valid, i_st_nt, i_lk_l1_hit, i_lk_l2_hit, i_fence, i_bus_ready;
	nts_pkg::st_kind_e i_st_kind;
	nts_pkg::mem_type_e i_st_type, i_rd_type, o_bus_type;
	logic [31:0] i_st_addr, i_dest_index, o_l1_wr_addr, o_l2_flush_addr, o_bus_addr;
	logic [31:0] o_gp_fault_addr;
	logic [127:0] i_st_data, i_st_mask, o_l1_wr_data, o_l2_flush_data, o_bus_data;
	logic [15:0] o_l1_wr_be, o_l2_flush_be, o_bus_be;
	logic o_st_ready, o_fence_ready, o_fence_done, o_l1_wr_valid, o_l2_flush_valid;
	logic o_bus_valid, o_bus_ordered, o_gp_fault, o_rd_fill_ok, o_wc_busy;
	exp_s exp_q[$];
	int n_mismatch = 0;
	int total_checks = 0;
	integer seed;

	nontemporal_store_path #(.ADDR_W(32)) u_dut (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_st_valid(i_st_valid), .o_st_ready(o_st_ready),
		.i_st_kind(i_st_kind), .i_st_nt(i_st_nt), .i_st_type(i_st_type), .i_st_addr(i_st_addr),
		.i_dest_index(i_dest_index), .i_st_data(i_st_data), .i_st_mask(i_st_mask),
		.i_lk_l1_hit(i_lk_l1_hit), .i_lk_l2_hit(i_lk_l2_hit), .i_fence(i_fence),
		.o_fence_ready(o_fence_ready), .o_fence_done(o_fence_done),
		.o_l1_wr_valid(o_l1_wr_valid), .o_l1_wr_addr(o_l1_wr_addr),
		.o_l1_wr_data(o_l1_wr_data), .o_l1_wr_be(o_l1_wr_be),
		.o_l2_flush_valid(o_l2_flush_valid), .o_l2_flush_addr(o_l2_flush_addr),
		.o_l2_flush_data(o_l2_flush_data), .o_l2_flush_be(o_l2_flush_be),
		.o_bus_valid(o_bus_valid), .i_bus_ready(i_bus_ready), .o_bus_addr(o_bus_addr),
		.o_bus_data(o_bus_data), .o_bus_be(o_bus_be), .o_bus_type(o_bus_type),
		.o_bus_ordered(o_bus_ordered), .o_gp_fault(o_gp_fault),
		.o_gp_fault_addr(o_gp_fault_addr), .i_rd_type(i_rd_type),
		.o_rd_fill_ok(o_rd_fill_ok), .o_wc_busy(o_wc_busy)
	);
	bus_agent u_bus (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(o_bus_valid), .o_ready(i_bus_ready));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic cmp_v(input string name, input logic [127:0] e, input logic [127:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : cmp_v

	function automatic logic [127:0] bmask(input logic [15:0] be);
		for (int i = 0; i < 16; i++) bmask[8*i+:8] = {8{be[i]}};
	endfunction : bmask

	function automatic logic [127:0] rnd128();
		rnd128 = {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction : rnd128

	task automatic push(input logic [2:0] k, input logic [31:0] a, input logic [127:0] d,
			input logic [15:0] be, input logic [2:0] ty, input logic ord);
		exp_s e;
		e = '{k, a, d, be, ty, ord};
		exp_q.push_back(e);
	endtask : push

	task automatic take(input logic [2:0] k, input logic [31:0] a, input logic [127:0] d,
			input logic [15:0] be, input logic [2:0] ty, input logic ord);
		exp_s e;
		if (exp_q.size() == 0) begin
			cmp_v("unexpected_kind", 128'h0, k);
			return;
		end
		e = exp_q.pop_front();
		cmp_v("kind", e.k, k);
		cmp_v("addr", e.a, a);
		if (k < 3'h4) cmp_v("be", e.be, be);
		if (k < 3'h4) cmp_v("data", e.d & bmask(e.be), d & bmask(e.be));
		if (k == 3'h3) cmp_v("type", e.ty, ty);
		if (k == 3'h3) cmp_v("ordered", e.ord, ord);
	endtask : take

	always @(posedge i_clk) begin
		if (i_rstn === 1'b1) begin
			if (o_l1_wr_valid === 1'b1) take(3'h1, o_l1_wr_addr, o_l1_wr_data, o_l1_wr_be, 3'h0, 1'b0);
			if (o_l2_flush_valid === 1'b1) take(3'h2, o_l2_flush_addr, o_l2_flush_data,
				o_l2_flush_be, 3'h0, 1'b0);
			if (o_bus_valid === 1'b1 && i_bus_ready === 1'b1) take(3'h3, o_bus_addr, o_bus_data,
				o_bus_be, o_bus_type, o_bus_ordered);
			if (o_gp_fault === 1'b1) take(3'h4, o_gp_fault_addr, 128'h0, 16'h0, 3'h0, 1'b0);
			if (o_fence_done === 1'b1) take(3'h5, 32'h0, 128'h0, 16'h0, 3'h0, 1'b0);
		end
	end

	task automatic st(input nts_pkg::st_kind_e kd, input logic nt, input nts_pkg::mem_type_e ty,
			input logic [31:0] a, input logic [31:0] di, input logic [127:0] d,
			input logic [127:0] m, input logic l1, input logic l2);
		int n;
		i_st_valid <= 1'b1;
		i_st_kind <= kd;
		i_st_nt <= nt;
		i_st_type <= ty;
		i_st_addr <= a;
		i_dest_index <= di;
		i_st_data <= d;
		i_st_mask <= m;
		i_lk_l1_hit <= l1;
		i_lk_l2_hit <= l2;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_st_ready !== 1'b1 && n < 50);
		if (n >= 50) cmp_v("store_taken", 128'h1, 128'h0);
	endtask : st

	task automatic gap;
		i_st_valid <= 1'b0;
		@(posedge i_clk);
	endtask : gap

	task automatic fence;
		int n;
		i_fence <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_fence_ready !== 1'b1 && n < 50);
		i_fence <= 1'b0;
	endtask : fence

	task automatic wait_empty;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 100) begin
			@(posedge i_clk);
			n++;
		end
		cmp_v("pending", 128'h0, exp_q.size());
	endtask : wait_empty

	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		logic [127:0] d, m, e, b;
		logic [63:0] q;
		logic [7:0] mb;
		seed = 32'h082c;
		i_rstn = 1'b0;
		i_st_valid = 1'b0;
		i_st_kind = nts_pkg::plain_store;
		i_st_nt = 1'b0;
		i_st_type = nts_pkg::write_back_type;
		i_rd_type = nts_pkg::uncacheable_type;
		{i_st_addr, i_dest_index, i_st_data, i_st_mask} = '0;
		{i_lk_l1_hit, i_lk_l2_hit, i_fence} = 3'h0;
		repeat (3) @(posedge i_clk);
		i_rstn <= 1'b1;
		// Read fill permission per region type
		for (int t = 0; t < 5; t++) begin
			i_rd_type <= nts_pkg::mem_type_e'(t);
			@(posedge i_clk);
			@(posedge i_clk);
			cmp_v("fill_ok", (t == int'(nts_pkg::write_through_type) ||
				t == int'(nts_pkg::write_back_type)), o_rd_fill_ok);
		end
		// Strongly ordered regions ignore the hint, even on a cache hit
		for (int j = 0; j < 2; j++) begin
			d = rnd128();
			push(3'h3, 32'h3000, d, 16'hffff,
				j ? nts_pkg::write_protect_type : nts_pkg::uncacheable_type, 1'b1);
			st(nts_pkg::stream_store_double_quad, 1'b1, nts_pkg::mem_type_e'(j ? 3 : 0),
				32'h3000, 32'h0, d, 128'h0, 1'b1, 1'b0);
		end
		// Cached paths back to back: quad, plain, packed single, masked quad, then a faulting packed single
		d = rnd128();
		q = d[63:0];
		push(3'h1, 32'h2000, {q, q}, 16'h00ff, 3'h0, 1'b0);
		st(nts_pkg::stream_store_quad, 1'b1, nts_pkg::write_back_type, 32'h2000, 32'h0, d,
			128'h0, 1'b1, 1'b0);
		d = rnd128();
		push(3'h1, 32'h2030, d, 16'hffff, 3'h0, 1'b0);
		st(nts_pkg::plain_store, 1'b0, nts_pkg::write_through_type, 32'h2030, 32'h0, d,
			128'h0, 1'b0, 1'b0);
		d = rnd128();
		push(3'h2, 32'h2010, d, 16'hffff, 3'h0, 1'b0);
		st(nts_pkg::stream_store_packed_single, 1'b1, nts_pkg::write_through_type, 32'h2010,
			32'h0, d, 128'h0, 1'b0, 1'b1);
		d = rnd128();
		m = rnd128();
		m[7] = 1'b1;
		for (int i = 0; i < 8; i++) mb[i] = m[8*i+7];
		push(3'h1, 32'h2000, {d[63:0], d[63:0]}, {mb, 8'h00}, 3'h0, 1'b0);
		st(nts_pkg::masked_stream_store_quad, 1'b1, nts_pkg::write_back_type, 32'h2ff0,
			32'h2008, d, m, 1'b1, 1'b0);
		push(3'h4, 32'h2004, 128'h0, 16'h0, 3'h0, 1'b0);
		st(nts_pkg::stream_store_packed_single, 1'b1, nts_pkg::write_back_type, 32'h2004,
			32'h0, rnd128(), 128'h0, 1'b1, 1'b0);
		gap();
		wait_empty();
		// Fence after in-place merges pushes nothing out
		push(3'h5, 32'h0, 128'h0, 16'h0, 3'h0, 1'b0);
		fence();
		wait_empty();
		// Misses and a write-combining region store combine in one line; later bytes win; first type goes on the bus
		e = rnd128();
		q = e[63:0];
		b = rnd128();
		m = rnd128();
		e = {q, q};
		for (int i = 0; i < 16; i++) begin
			m[8*i+7] = (i == 0 || (i >= 8 && i < 12));
			if (m[8*i+7]) e[8*i+:8] = b[8*i+:8];
		end
		d = rnd128();
		push(3'h3, 32'h1040, e, 16'hff01, nts_pkg::write_back_type, 1'b0);
		push(3'h3, 32'h1060, d, 16'hffff, nts_pkg::write_back_type, 1'b0);
		push(3'h5, 32'h0, 128'h0, 16'h0, 3'h0, 1'b0);
		st(nts_pkg::stream_store_quad, 1'b1, nts_pkg::write_back_type, 32'h1048, 32'h0,
			{d[127:64], q}, 128'h0, 1'b0, 1'b0);
		st(nts_pkg::masked_stream_store_wide, 1'b1, nts_pkg::write_combining_type, 32'h2000,
			32'h1040, b, m, 1'b1, 1'b0);
		st(nts_pkg::stream_store_double_quad, 1'b1, nts_pkg::write_through_type, 32'h1060,
			32'h0, d, 128'h0, 1'b0, 1'b0);
		gap();
		cmp_v("wc_busy", 128'h1, o_wc_busy);
		fence();
		wait_empty();
		@(posedge i_clk);
		cmp_v("wc_busy", 128'h0, o_wc_busy);
		// Another line or an uncached store pushes the combining line out first
		d = rnd128();
		b = rnd128();
		push(3'h3, 32'h1080, d, 16'hffff, nts_pkg::write_through_type, 1'b0);
		push(3'h3, 32'h10c0, b, 16'hffff, nts_pkg::write_back_type, 1'b0);
		push(3'h3, 32'h3010, d, 16'hffff, nts_pkg::uncacheable_type, 1'b1);
		st(nts_pkg::stream_store_double_quad, 1'b1, nts_pkg::write_through_type, 32'h1080,
			32'h0, d, 128'h0, 1'b0, 1'b0);
		st(nts_pkg::stream_store_double_quad, 1'b1, nts_pkg::write_back_type, 32'h10c0,
			32'h0, b, 128'h0, 1'b0, 1'b0);
		st(nts_pkg::stream_store_double_quad, 1'b1, nts_pkg::uncacheable_type, 32'h3010,
			32'h0, d, 128'h0, 1'b0, 1'b0);
		gap();
		wait_empty();
		complete_run();
	end
endmodule : test_nontemporal_store_path
